/* ulsr_top.sv */
// receive line status block with axi4-lite register slave
`timescale 1ns/10ps
module ulsr_top
  import ulsr_pkg::*;
(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // serial line
  input  wire logic              serial_in
);
  //==================================================================
  // state
  typedef struct packed {
    logic                             aw_held;
    logic [ADDR_W-1:0]                aw_addr;
    logic                             w_held;
    logic [31:0]                      w_data;
    logic [3:0]                       w_strb;
    logic                             awready;
    logic                             wready;
    logic                             bvalid;
    logic [1:0]                       bresp;
    logic                             arready;
    logic                             rvalid;
    logic [31:0]                      rdata;
    logic [1:0]                       rresp;
    logic [7:0]                       line_ctl;
    logic                             fifo_en;
    logic [15:0]                      divisor;
    ulsr_rx_state_t                   rx_state;
    logic [15:0]                      tick_cnt;
    logic [3:0]                       os_cnt;
    logic [2:0]                       bit_cnt;
    logic [7:0]                       shift;
    logic                             par_bit;
    logic [7:0]                       hold_data;
    logic                             hold_valid;
    logic [FIFO_DEPTH-1:0][ENT_W-1:0] mem;
    logic [PTR_W-1:0]                 wptr;
    logic [PTR_W-1:0]                 rptr;
    logic [CNT_W-1:0]                 count;
    logic                             head_rev;
    logic                             st_oe;
    logic                             st_pe;
    logic                             st_fe;
    logic                             st_brk;
  } ulsr_state_t;

  ulsr_state_t      s_reg;
  ulsr_state_t      s_next;
  logic [15:0]      div_last;
  logic             baud_tick;
  logic             char_done;
  logic             par_en;
  logic             line_break;
  logic             par_bad;
  logic             tag_pe;
  logic             tag_fe;
  logic             tag_brk;
  logic             ar_take;
  logic             stat_rd;
  logic             buf_rd;
  logic             wr_go;
  logic             fifo_pop;

  function automatic logic [7:0] status_value(input ulsr_state_t s);
    logic [7:0] v;
    v = '0;
    v[STAT_AVAIL] = s.fifo_en ? (s.count != '0) : s.hold_valid;
    v[STAT_OVR]   = s.st_oe;
    v[STAT_PAR]   = s.st_pe;
    v[STAT_FRM]   = s.st_fe;
    v[STAT_BRK]   = s.st_brk;
    return v;
  endfunction

  //==================================================================
  // character events
  assign div_last  = (s_reg.divisor == '0) ? '0 : s_reg.divisor - 16'h0001;
  assign baud_tick = s_reg.tick_cnt >= div_last;
  assign char_done = (s_reg.rx_state == RX_STOP) && baud_tick
                     && (s_reg.os_cnt == OS_LAST);
  assign par_en    = s_reg.line_ctl[CTL_PAR_EN];
  assign line_break = char_done && !serial_in && (s_reg.shift == '0)
                      && (!par_en || !s_reg.par_bit);
  assign par_bad = par_en && ((^{s_reg.shift, s_reg.par_bit})
                              == s_reg.line_ctl[CTL_EVEN]);
  assign tag_brk = line_break;
  assign tag_fe  = char_done && !serial_in;
  assign tag_pe  = line_break || par_bad;
  assign ar_take = arvalid && s_reg.arready;
  assign stat_rd = ar_take && (araddr == OFS_LINE_STATUS);
  assign buf_rd  = ar_take && (araddr == OFS_RX_BUFFER);
  assign wr_go   = s_reg.aw_held && s_reg.w_held && !s_reg.bvalid;
  assign fifo_pop = buf_rd && s_reg.fifo_en && (s_reg.count != '0);

  //==================================================================
  // next state
  always_comb
  begin
    logic flush;
    flush  = 1'b0;
    s_next = s_reg;
    // write channel: address and data taken in either order
    if (awvalid && s_reg.awready)
    begin
      s_next.aw_held = 1'b1;
      s_next.aw_addr = awaddr;
    end
    if (wvalid && s_reg.wready)
    begin
      s_next.w_held = 1'b1;
      s_next.w_data = wdata;
      s_next.w_strb = wstrb;
    end
    if (bready && s_reg.bvalid)
      s_next.bvalid = 1'b0;
    if (wr_go)
    begin
      s_next.aw_held = 1'b0;
      s_next.w_held  = 1'b0;
      s_next.bvalid  = 1'b1;
      s_next.bresp   = RESP_OKAY;
      case (s_reg.aw_addr)
        OFS_LINE_CONTROL:
          if (s_reg.w_strb[0])
            s_next.line_ctl = s_reg.w_data[7:0];
        OFS_FIFO_CONTROL:
          if (s_reg.w_strb[0])
          begin
            s_next.fifo_en = s_reg.w_data[FIFO_ON];
            // mode change flushes so no stale character crosses over
            flush = s_reg.w_data[FIFO_FLUSH]
                    || (s_reg.w_data[FIFO_ON] != s_reg.fifo_en);
          end
        OFS_DIVISOR:
        begin
          if (s_reg.w_strb[0])
            s_next.divisor[7:0] = s_reg.w_data[7:0];
          if (s_reg.w_strb[1])
            s_next.divisor[15:8] = s_reg.w_data[15:8];
        end
        OFS_RX_BUFFER, OFS_LINE_STATUS:
          s_next.bresp = RESP_OKAY;
        default:
          s_next.bresp = RESP_SLVERR;
      endcase
    end
    s_next.awready = !s_next.aw_held && !s_next.bvalid;
    s_next.wready  = !s_next.w_held && !s_next.bvalid;
    // read channel
    if (rready && s_reg.rvalid)
      s_next.rvalid = 1'b0;
    if (ar_take)
    begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = RESP_OKAY;
      s_next.rdata  = '0;
      case (araddr)
        OFS_RX_BUFFER:
          s_next.rdata[7:0] = s_reg.fifo_en ? s_reg.mem[s_reg.rptr][7:0]
                                            : s_reg.hold_data;
        OFS_LINE_STATUS:
          s_next.rdata[7:0] = status_value(s_reg);
        OFS_LINE_CONTROL:
          s_next.rdata[7:0] = s_reg.line_ctl;
        OFS_FIFO_CONTROL:
          s_next.rdata[FIFO_ON] = s_reg.fifo_en;
        OFS_DIVISOR:
          s_next.rdata[15:0] = s_reg.divisor;
        default:
          s_next.rresp = RESP_SLVERR;
      endcase
    end
    s_next.arready = !s_next.rvalid;
    // clears come first so that a same-cycle event wins
    // read clears error flags
    if (stat_rd)
    begin
      s_next.st_oe  = 1'b0;
      s_next.st_pe  = 1'b0;
      s_next.st_fe  = 1'b0;
      s_next.st_brk = 1'b0;
    end
    if (buf_rd && !s_reg.fifo_en)
      s_next.hold_valid = 1'b0;
    if (fifo_pop)
    begin
      s_next.rptr  = s_reg.rptr + 4'h1;
      s_next.count = s_reg.count - 5'h01;
    end
    //==================================================================
    // receiver, sampling at mid-bit on a 16x baud tick
    s_next.tick_cnt = baud_tick ? '0 : s_reg.tick_cnt + 16'h0001;
    if (baud_tick)
    begin
      s_next.os_cnt = s_reg.os_cnt + 4'h1;
      case (s_reg.rx_state)
        RX_IDLE:
        begin
          s_next.os_cnt = '0;
          if (!serial_in)
            s_next.rx_state = RX_START;
        end
        RX_START:
          if (s_reg.os_cnt == OS_MID)
          begin
            s_next.os_cnt   = '0;
            s_next.bit_cnt  = '0;
            s_next.rx_state = serial_in ? RX_IDLE : RX_DATA;
          end
        RX_DATA:
          if (s_reg.os_cnt == OS_LAST)
          begin
            s_next.shift   = {serial_in, s_reg.shift[7:1]};
            s_next.bit_cnt = s_reg.bit_cnt + 3'h1;
            if (s_reg.bit_cnt == BIT_LAST)
              s_next.rx_state = par_en ? RX_PARITY : RX_STOP;
          end
        RX_PARITY:
          if (s_reg.os_cnt == OS_LAST)
          begin
            s_next.par_bit  = serial_in;
            s_next.rx_state = RX_STOP;
          end
        RX_STOP:
          if (s_reg.os_cnt == OS_LAST)
          begin
            if (serial_in)
              s_next.rx_state = RX_IDLE;
            // hold off until the line returns high
            else if (line_break)
              s_next.rx_state = RX_BREAK;
            else
            begin
              // low stop taken as next start bit
              s_next.rx_state = RX_DATA;
              s_next.bit_cnt  = '0;
            end
          end
        RX_BREAK:
        begin
          s_next.os_cnt = '0;
          if (serial_in)
            s_next.rx_state = RX_IDLE;
        end
        default:
          s_next.rx_state = RX_IDLE;
      endcase
    end
    //==================================================================
    // character delivery
    if (char_done)
    begin
      if (!s_reg.fifo_en)
      begin
        if (s_reg.hold_valid && !buf_rd)
          s_next.st_oe = 1'b1;
        s_next.hold_data  = s_reg.shift;
        s_next.hold_valid = 1'b1;
        s_next.st_pe  = s_next.st_pe | tag_pe;
        s_next.st_fe  = s_next.st_fe | tag_fe;
        s_next.st_brk = s_next.st_brk | tag_brk;
      end
      else if ((s_reg.count == FIFO_FULL_CNT) && !fifo_pop)
        s_next.st_oe = 1'b1;
      else
      begin
        s_next.mem[s_reg.wptr] = {tag_brk, tag_fe, tag_pe, s_reg.shift};
        s_next.wptr  = s_reg.wptr + 4'h1;
        s_next.count = s_next.count + 5'h01;
      end
    end
    // flags revealed when entry reaches head
    if (s_next.count == '0)
      s_next.head_rev = 1'b0;
    else if (fifo_pop || !s_reg.head_rev)
    begin
      s_next.head_rev = 1'b1;
      s_next.st_pe  = s_next.st_pe | s_next.mem[s_next.rptr][ENT_PAR];
      s_next.st_fe  = s_next.st_fe | s_next.mem[s_next.rptr][ENT_FRM];
      s_next.st_brk = s_next.st_brk | s_next.mem[s_next.rptr][ENT_BRK];
    end
    if (flush)
    begin
      s_next.wptr       = '0;
      s_next.rptr       = '0;
      s_next.count      = '0;
      s_next.head_rev   = 1'b0;
      s_next.hold_valid = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_reg         <= '0;
      s_reg.divisor <= DIV_RESET;
      s_reg.line_ctl <= CTL_RESET;
    end
    else
      s_reg <= s_next;
  end

  assign awready = s_reg.awready;
  assign wready  = s_reg.wready;
  assign bvalid  = s_reg.bvalid;
  assign bresp   = s_reg.bresp;
  assign arready = s_reg.arready;
  assign rvalid  = s_reg.rvalid;
  assign rdata   = s_reg.rdata;
  assign rresp   = s_reg.rresp;

  //==================================================================
  // checks
  chk_lsr_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    stat_rd && !char_done && (s_reg.head_rev || s_reg.count == '0)
    |=> !s_reg.st_oe && !s_reg.st_pe && !s_reg.st_fe && !s_reg.st_brk)
    else $error("line status read did not clear error flags");
  chk_break_flags: assert property (@(posedge aclk) disable iff (!aresetn)
    char_done && line_break && !s_reg.fifo_en
    |=> s_reg.st_brk && s_reg.st_fe && s_reg.st_pe && s_reg.hold_data == '0)
    else $error("break did not raise break, framing and parity flags");
  chk_break_once: assert property (@(posedge aclk) disable iff (!aresetn)
    char_done && line_break ##1 !serial_in |=> s_reg.rx_state == RX_BREAK)
    else $error("break loaded more than one character");
  chk_resync_start: assert property (@(posedge aclk) disable iff (!aresetn)
    char_done && !serial_in && !line_break
    |=> s_reg.rx_state == RX_DATA && s_reg.bit_cnt == '0)
    else $error("receiver did not resynchronise on bad stop");
  chk_overrun_replace: assert property (@(posedge aclk) disable iff (!aresetn)
    char_done && !s_reg.fifo_en && s_reg.hold_valid && !buf_rd
    |=> s_reg.st_oe && s_reg.hold_data == $past(s_reg.shift))
    else $error("overrun without fifo mishandled");
  chk_overrun_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    char_done && s_reg.fifo_en && s_reg.count == FIFO_FULL_CNT && !fifo_pop
    |=> s_reg.st_oe && s_reg.count == FIFO_FULL_CNT
        && s_reg.wptr == $past(s_reg.wptr))
    else $error("full fifo overrun changed fifo");
  chk_parity_off: assert property (@(posedge aclk) disable iff (!aresetn)
    char_done && !par_en && !line_break && !stat_rd && !s_reg.fifo_en
    |=> s_reg.st_pe == $past(s_reg.st_pe))
    else $error("parity flagged while parity disabled");
  chk_head_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_reg.fifo_en && s_reg.head_rev && !fifo_pop && !stat_rd && !wr_go
    |=> s_reg.st_fe == $past(s_reg.st_fe) && s_reg.st_pe == $past(s_reg.st_pe))
    else $error("error flag shown before its character reached head");
  chk_head_reveal: assert property (@(posedge aclk) disable iff (!aresetn)
    char_done && s_reg.fifo_en && s_reg.count == '0 && !wr_go
    |=> (!$past(tag_fe) || s_reg.st_fe) && (!$past(tag_pe) || s_reg.st_pe))
    else $error("tags of head character not revealed");
  chk_data_avail: assert property (@(posedge aclk) disable iff (!aresetn)
    buf_rd && !s_reg.fifo_en && !char_done |=> !s_reg.hold_valid)
    else $error("buffer read did not clear data available");
endmodule

/* ulsr_pkg.sv */
// register map, field layout and constants of the receive line status block
//==================================================================
package ulsr_pkg;
  //==================================================================
  // register offsets (byte addresses)
  localparam int unsigned ADDR_W            = 8;
  localparam logic [7:0]  OFS_RX_BUFFER     = 8'h00;
  localparam logic [7:0]  OFS_LINE_STATUS   = 8'h04;
  localparam logic [7:0]  OFS_LINE_CONTROL  = 8'h08;
  localparam logic [7:0]  OFS_FIFO_CONTROL  = 8'h0C;
  localparam logic [7:0]  OFS_DIVISOR       = 8'h10;
  //==================================================================
  // field positions
  localparam int unsigned STAT_AVAIL = 0;
  localparam int unsigned STAT_OVR   = 1;
  localparam int unsigned STAT_PAR   = 2;
  localparam int unsigned STAT_FRM   = 3;
  localparam int unsigned STAT_BRK   = 4;
  localparam int unsigned CTL_PAR_EN = 3;
  localparam int unsigned CTL_EVEN   = 4;
  localparam int unsigned FIFO_ON    = 0;
  localparam int unsigned FIFO_FLUSH = 1;
  localparam int unsigned ENT_PAR    = 8;
  localparam int unsigned ENT_FRM    = 9;
  localparam int unsigned ENT_BRK    = 10;
  localparam int unsigned ENT_W      = 11;
  //==================================================================
  // sizes, counts and reset values
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned PTR_W      = 4;
  localparam int unsigned CNT_W      = 5;
  localparam logic [CNT_W-1:0] FIFO_FULL_CNT = 5'h10;
  localparam logic [3:0]  OS_MID     = 4'h7;
  localparam logic [3:0]  OS_LAST    = 4'hF;
  localparam logic [2:0]  BIT_LAST   = 3'h7;
  localparam logic [15:0] DIV_RESET  = 16'h0001;
  localparam logic [7:0]  CTL_RESET  = 8'h00;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP, RX_BREAK
  } ulsr_rx_state_t;
endpackage

/* ulsr_tx_model.sv */
// far-side serial transmitter model driving the receive line
`timescale 1ns/10ps
//==================================================================
// transmitter model
module ulsr_tx_model
(
  // clock
  input  wire logic aclk,
  // serial line, idle high
  output logic      serial_out
);
  initial serial_out = 1'b1;

  // one bit time at divisor 1 is 16 clocks; called just after an edge
  task automatic bit_out(input logic b);
    serial_out <= b;
    repeat (16) @(posedge aclk);
  endtask

  // even parity when par is set and flip is clear, odd when flip is set; skip_start resumes after a low stop bit
  task automatic frame(input logic [7:0] d, input logic par,
                       input logic flip, input logic stop,
                       input logic skip_start);
    int i;
    if (!skip_start)
      bit_out(1'b0);
    for (i = 0; i < 8; i++)
      bit_out(d[i]);
    if (par)
      bit_out(^d ^ flip);
    // no forced idle after: a low stop runs straight into the next frame
    bit_out(stop);
  endtask

  // line low well past a whole frame, then idle again
  task automatic brk();
    repeat (14) bit_out(1'b0);
    repeat (2) bit_out(1'b1);
  endtask
endmodule

/* ulsr_top_tb_top.sv */
// self-checking testbench of the receive line status block
`timescale 1ns/10ps
module ulsr_top_tb_top
  import ulsr_pkg::*;
();
  //==================================================================
  // signals
  logic              aclk;
  logic              aresetn;
  logic [ADDR_W-1:0] awaddr;
  logic              awvalid;
  logic              awready;
  logic [31:0]       wdata;
  logic [3:0]        wstrb;
  logic              wvalid;
  logic              wready;
  logic [1:0]        bresp;
  logic              bvalid;
  logic              bready;
  logic [ADDR_W-1:0] araddr;
  logic              arvalid;
  logic              arready;
  logic [31:0]       rdata;
  logic [1:0]        rresp;
  logic              rvalid;
  logic              rready;
  logic              serial_in;
  int                num_errors;
  int                checks;
  int                cycles;
  int                seed;
  int                i;
  logic [33:0]       rq[$];
  logic [1:0]        bq[$];
  logic [7:0]        ch[17];

  initial aclk = 1'b0;
  always #5 aclk = ~aclk;

  ulsr_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .serial_in(serial_in));

  ulsr_tx_model tx (.aclk(aclk), .serial_out(serial_in));

  //==================================================================
  // checking and closing
  task automatic chk(input string what, input logic [33:0] seen,
                     input logic [33:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // readies only move on rising edges, so the falling edge sees them settled
  always @(negedge aclk)
  begin
    if (rvalid && rready)
      chk("read", {rresp, rdata}, rq.pop_front());
    if (bvalid && bready)
      chk("bresp", {32'h0000_0000, bresp}, {32'h0000_0000, bq.pop_front()});
  end

  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      num_errors++;
      conclude();
    end
  end

  //==================================================================
  // bus tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    logic ta, tw, da, dw;
    da = 1'b0;
    dw = 1'b0;
    bq.push_back(r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(da && dw))
    begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge aclk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
      da |= ta;
      dw |= tw;
    end
    ta = 1'b0;
    while (!ta)
    begin
      @(negedge aclk);
      ta = bvalid;
      @(posedge aclk);
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    logic t;
    t = 1'b0;
    rq.push_back(e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!t)
    begin
      @(negedge aclk);
      t = arvalid && arready;
      @(posedge aclk);
      if (t)
        arvalid <= 1'b0;
    end
    t = 1'b0;
    while (!t)
    begin
      @(negedge aclk);
      t = rvalid;
      @(posedge aclk);
    end
    rready <= 1'b0;
  endtask

  task automatic ls(input logic [7:0] e);
    rd(OFS_LINE_STATUS, {RESP_OKAY, 24'h00_0000, e});
  endtask

  task automatic rb(input logic [7:0] e);
    rd(OFS_RX_BUFFER, {RESP_OKAY, 24'h00_0000, e});
  endtask

  //==================================================================
  // main sequence
  initial
  begin
    seed = 32'h0000_a40b;
    aresetn = 1'b0;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    for (i = 0; i < 17; i++)
      ch[i] = 8'($random(seed));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    ls(8'h00);
    rd(OFS_LINE_CONTROL, {RESP_OKAY, 32'h0000_0000});
    rd(OFS_DIVISOR, {RESP_OKAY, 32'h0000_0001});
    rd(8'h20, {RESP_SLVERR, 32'h0000_0000});
    wr(8'h20, 32'h0000_00FF, RESP_SLVERR);
    // single buffer: hold, overwrite on overrun, read clears
    tx.frame(ch[0], 1'b0, 1'b0, 1'b1, 1'b0);
    ls(8'h01);
    rb(ch[0]);
    ls(8'h00);
    tx.frame(ch[1], 1'b0, 1'b0, 1'b1, 1'b0);
    tx.frame(ch[2], 1'b0, 1'b0, 1'b1, 1'b0);
    ls(8'h03);
    rb(ch[2]);
    ls(8'h00);
    wr(OFS_LINE_CONTROL, 32'h0000_0018, RESP_OKAY);
    tx.frame(ch[3], 1'b1, 1'b1, 1'b1, 1'b0);
    ls(8'h05);
    rb(ch[3]);
    ls(8'h00);
    wr(OFS_LINE_CONTROL, 32'h0000_0010, RESP_OKAY);
    tx.frame(ch[4], 1'b0, 1'b0, 1'b1, 1'b0);
    ls(8'h01);
    rb(ch[4]);
    // break without fifo: flags show at once
    tx.brk();
    ls(8'h1D);
    rb(8'h00);
    // fifo mode: flags travel with their character
    wr(OFS_FIFO_CONTROL, 32'h0000_0001, RESP_OKAY);
    rd(OFS_FIFO_CONTROL, {RESP_OKAY, 32'h0000_0001});
    wr(OFS_LINE_CONTROL, 32'h0000_0018, RESP_OKAY);
    tx.frame(ch[5], 1'b1, 1'b0, 1'b1, 1'b0);
    tx.frame(ch[6], 1'b1, 1'b1, 1'b1, 1'b0);
    ls(8'h01);
    rb(ch[5]);
    ls(8'h05);
    rb(ch[6]);
    ls(8'h00);
    // nonzero data keeps the bad stop from looking like a break
    tx.frame(ch[7] | 8'h01, 1'b1, 1'b0, 1'b0, 1'b0);
    tx.frame(ch[8], 1'b1, 1'b0, 1'b1, 1'b1);
    ls(8'h09);
    rb(ch[7] | 8'h01);
    ls(8'h01);
    rb(ch[8]);
    tx.brk();
    ls(8'h1D);
    rb(8'h00);
    ls(8'h00);
    for (i = 0; i < 17; i++)
      tx.frame(ch[i], 1'b1, 1'b0, 1'b1, 1'b0);
    ls(8'h03);
    for (i = 0; i < 16; i++)
      rb(ch[i]);
    ls(8'h00);
    // flush drops a held character
    tx.frame(ch[9], 1'b1, 1'b0, 1'b1, 1'b0);
    wr(OFS_FIFO_CONTROL, 32'h0000_0003, RESP_OKAY);
    ls(8'h00);
    conclude();
  end
endmodule
